// file: analog_value_gain_offset_scaler_tb.sv
`timescale 1ns/1ps
`default_nettype none

module analog_value_gain_offset_scaler_tb;
    import scaler_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic core_clk_i;
    logic arst_n_i;
    logic offer_q;
    logic [MV_W-1:0] offer_mv_q;
    logic conv_valid;
    logic [MV_W-1:0] conv_mv;
    logic cfg_load_i;
    scale_cfg_s cfg_i;
    logic cfg_reject_o;
    scale_cfg_s cfg_o;
    logic value_valid_o;
    logic signed [VALUE_W-1:0] scaled_actual_value_o;
    scale_cfg_s cfg_model;
    logic signed [VALUE_W-1:0] exp_q[$];
    logic [31:0] seed;
    int fail_count;
    int total_checks;
    // voltage, gain and offset corners; settings derived from low and high process values
    int tv_mv[13] = '{0, 3000, 10000, 6750, 10000, 5000, 10000, 20, 20, 12000, 65535, 500, 9999};
    int tv_g[13] = '{10, 10, 10, 400, 400, 1, 1000, 1, 10, 100, 1000, -1, -1000};
    int tv_o[13] = '{-30, -30, -30, 1000, 1000, 0, -10000, 0, 0, 500, 10000, 0, -10000};
    int bad_g[4] = '{1001, -1001, 100, 100};
    int bad_o[4] = '{0, 0, 10001, -10001};

    converter_model u_conv (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .offer_i(offer_q),
        .offer_mv_i(offer_mv_q), .conv_valid_o(conv_valid), .conv_mv_o(conv_mv));

    gain_offset_scaler u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
        .analog_voltage_valid_i(conv_valid), .analog_voltage_input_i(conv_mv),
        .cfg_load_i(cfg_load_i), .cfg_i(cfg_i), .cfg_reject_o(cfg_reject_o), .cfg_o(cfg_o),
        .value_valid_o(value_valid_o), .scaled_actual_value_o(scaled_actual_value_o));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction : xorshift

    // saturate, scale in hundredths, cut the fraction toward zero, then shift
    function automatic logic signed [VALUE_W-1:0] expect_value(input logic [MV_W-1:0] mv, input scale_cfg_s c);
        int smp;
        smp = (mv > 16'd10000) ? 1000 : int'(mv) / 10;
        expect_value = VALUE_W'((smp * int'(c.gain)) / 100 + int'(c.offset));
    endfunction : expect_value

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic load_cfg(input int g, input int o, input logic ok);
        @(posedge core_clk_i);
        cfg_load_i <= 1'b1;
        cfg_i <= '{GAIN_W'(g), OFFSET_W'(o)};
        @(posedge core_clk_i);
        cfg_load_i <= 1'b0;
        #1;
        if (ok) begin
            cfg_model = '{GAIN_W'(g), OFFSET_W'(o)};
        end
        check("cfg_reject", !ok, cfg_reject_o);
        check("cfg_o", cfg_model, cfg_o);
    endtask : load_cfg

    task automatic send(input logic [MV_W-1:0] mv);
        @(posedge core_clk_i);
        offer_q <= 1'b1;
        offer_mv_q <= mv;
        exp_q.push_back(expect_value(mv, cfg_model));
    endtask : send

    // stop offering and let the pipeline empty
    task automatic drain();
        @(posedge core_clk_i);
        offer_q <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        check("pending results", 0, exp_q.size());
    endtask : drain

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // ************************************************************
    // consumer: every result pulse must match the oldest expectation
    // ************************************************************
    always @(posedge core_clk_i) begin
        if (value_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected value_valid", 0, 1);
            end else begin
                check("scaled_actual_value", exp_q.pop_front(), scaled_actual_value_o);
            end
        end
    end

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // the run needs well under 2000 cycles
    initial begin
        #100000;
        fail_count++;
        final_report();
    end

    initial begin
        arst_n_i = 1'b0;
        offer_q = 1'b0;
        offer_mv_q = '0;
        cfg_load_i = 1'b0;
        cfg_i = '0;
        cfg_model = '{GAIN_RESET, OFFSET_RESET};
        seed = 32'h30eb;
        fail_count = 0;
        total_checks = 0;
        repeat (5) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        #1;
        check("reset cfg_o", cfg_model, cfg_o);
        check("reset value", 0, {value_valid_o, cfg_reject_o, scaled_actual_value_o});
        // corners, including the boundary gains and offsets
        for (int i = 0; i < 13; i++) begin
            load_cfg(tv_g[i], tv_o[i], 1'b1);
            send(MV_W'(tv_mv[i]));
            drain();
        end
        // out-of-range settings are refused whole
        for (int i = 0; i < 4; i++) begin
            load_cfg(bad_g[i], bad_o[i], 1'b0);
        end
        // random settings with back-to-back random voltages
        for (int r = 0; r < 6; r++) begin
            seed = xorshift(seed);
            load_cfg(int'(seed % 2001) - 1000, int'((seed >> 11) % 20001) - 10000, 1'b1);
            for (int n = 0; n < 30; n++) begin
                seed = xorshift(seed);
                send(MV_W'(seed % 12000));
            end
            drain();
        end
        final_report();
    end
endmodule : analog_value_gain_offset_scaler_tb

`default_nettype wire

// file: converter_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// converter on the far side of the scaler's input
// ************************************************************
module converter_model (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // offer from the bench
    input wire logic offer_i,
    input wire logic [scaler_pkg::MV_W-1:0] offer_mv_i,
    // converter pins towards the scaler
    output logic conv_valid_o,
    output logic [scaler_pkg::MV_W-1:0] conv_mv_o
);
    import scaler_pkg::*;

    logic [MV_W-1:0] last_q;

    // remember the last offered voltage
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_q <= '0;
        end else if (offer_i) begin
            last_q <= offer_mv_i;
        end
    end

    // between offers the data lines show the inverse, so a stale read cannot pass
    assign conv_valid_o = offer_i;
    assign conv_mv_o = offer_i ? offer_mv_i : ~last_q;
endmodule : converter_model

`default_nettype wire

// file: gain_offset_scaler.sv
`timescale 1ns/1ps
`default_nettype none

module gain_offset_scaler (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // analog input in millivolts
    input wire logic analog_voltage_valid_i,
    input wire logic [scaler_pkg::MV_W-1:0] analog_voltage_input_i,
    // settings load
    input wire logic cfg_load_i,
    input wire scaler_pkg::scale_cfg_s cfg_i,
    output logic cfg_reject_o,
    output scaler_pkg::scale_cfg_s cfg_o,
    // scaled actual value
    output logic value_valid_o,
    output logic signed [scaler_pkg::VALUE_W-1:0] scaled_actual_value_o
);
    import scaler_pkg::*;

    // ************************************************************
    // input stage
    // ************************************************************
    wire logic sample_valid;
    wire logic [SAMPLE_W-1:0] sample;

    input_quantizer u_quant (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .analog_voltage_valid_i(analog_voltage_valid_i),
        .analog_voltage_input_i(analog_voltage_input_i),
        .sample_valid_o(sample_valid),
        .sample_o(sample)
    );

    // ************************************************************
    // settings
    // ************************************************************
    // out-of-range settings are refused whole so gain and offset never mismatch
    wire logic gain_ok;
    wire logic offset_ok;
    wire logic cfg_accept;
    assign gain_ok = in_range(OFFSET_W'(cfg_i.gain), OFFSET_W'(GAIN_MIN), OFFSET_W'(GAIN_MAX));
    assign offset_ok = in_range(cfg_i.offset, OFFSET_MIN, OFFSET_MAX);
    assign cfg_accept = cfg_load_i && gain_ok && offset_ok;

    scale_cfg_s cfg_q;
    logic reject_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_q <= '{gain: GAIN_RESET, offset: OFFSET_RESET};
            reject_q <= 1'b0;
        end else begin
            reject_q <= cfg_load_i && !cfg_accept;
            if (cfg_accept) begin
                cfg_q <= cfg_i;
            end
        end
    end

    assign cfg_o = cfg_q;
    assign cfg_reject_o = reject_q;

    // ************************************************************
    // multiply stage
    // ************************************************************
    // product in hundredths; the offset travels along so a settings load
    // between stages cannot pair one sample with mixed settings
    wire logic signed [PROD_W-1:0] sample_ext;
    wire logic signed [PROD_W-1:0] gain_ext;
    wire logic signed [PROD_W-1:0] prod_d;
    assign sample_ext = $signed({{(PROD_W-SAMPLE_W){1'b0}}, sample});
    assign gain_ext = PROD_W'(cfg_q.gain);
    assign prod_d = sample_ext * gain_ext;

    logic signed [PROD_W-1:0] prod_q;
    logic signed [OFFSET_W-1:0] offset_q;
    logic prod_valid_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prod_q <= '0;
            offset_q <= '0;
            prod_valid_q <= 1'b0;
        end else begin
            prod_valid_q <= sample_valid;
            if (sample_valid) begin
                prod_q <= prod_d;
                offset_q <= cfg_q.offset;
            end
        end
    end

    // ************************************************************
    // offset stage
    // ************************************************************
    // signed division truncates toward zero, so fractions are simply dropped
    wire logic signed [PROD_W-1:0] whole_part;
    wire logic signed [VALUE_W:0] sum;
    wire logic signed [VALUE_W-1:0] value_d;
    assign whole_part = prod_q / GAIN_DIVISOR;
    assign sum = (VALUE_W+1)'(whole_part) + (VALUE_W+1)'(offset_q);
    assign value_d = sum[VALUE_W-1:0];

    logic signed [VALUE_W-1:0] value_q;
    logic value_valid_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            value_q <= '0;
            value_valid_q <= 1'b0;
        end else begin
            value_valid_q <= prod_valid_q;
            if (prod_valid_q) begin
                value_q <= value_d;
            end
        end
    end

    assign scaled_actual_value_o = value_q;
    assign value_valid_o = value_valid_q;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_sample_in;
        sample_valid;
    endsequence

    sequence s_value_out;
        ##2 value_valid_o;
    endsequence

    a_gain_in_range: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        cfg_q.gain >= GAIN_MIN && cfg_q.gain <= GAIN_MAX)
        else $error("stored gain out of range");

    a_offset_in_range: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        cfg_q.offset >= OFFSET_MIN && cfg_q.offset <= OFFSET_MAX)
        else $error("stored offset out of range");

    a_bad_cfg_kept: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        cfg_load_i && !(gain_ok && offset_ok) |=> cfg_reject_o && $stable(cfg_q))
        else $error("bad settings not refused");

    a_good_cfg_taken: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        cfg_load_i && gain_ok && offset_ok |=> !cfg_reject_o && cfg_q == $past(cfg_i))
        else $error("good settings not stored");

    a_value_latency: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        s_sample_in |-> s_value_out)
        else $error("value not presented two cycles after sample");

    a_scale_math: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        sample_valid ##1 !cfg_load_i ##1 1'b1 |->
        scaled_actual_value_o == VALUE_W'(($signed(PROD_W'($past(sample, 2))) * PROD_W'($past(cfg_q.gain, 2))) / 100
                                 + PROD_W'($past(cfg_q.offset, 2))))
        else $error("value not sample times gain plus offset");

    a_value_bounded: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        value_valid_o |-> scaled_actual_value_o >= -16'sd20000 && scaled_actual_value_o <= 16'sd20000)
        else $error("value outside twenty thousand");

    a_value_holds: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !prod_valid_q |=> $stable(scaled_actual_value_o))
        else $error("value changed without a new sample");

endmodule : gain_offset_scaler

`default_nettype wire

// file: input_quantizer.sv
`timescale 1ns/1ps
`default_nettype none

module input_quantizer (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // voltage from converter
    input wire logic analog_voltage_valid_i,
    input wire logic [scaler_pkg::MV_W-1:0] analog_voltage_input_i,
    // internal sample
    output logic sample_valid_o,
    output logic [scaler_pkg::SAMPLE_W-1:0] sample_o
);
    import scaler_pkg::*;

    // ************************************************************
    // quantize and saturate
    // ************************************************************
    // a constant divisor keeps this a plain multiply-shift after synthesis
    wire logic over_full;
    wire logic [MV_W-1:0] steps;
    wire logic [SAMPLE_W-1:0] sample_d;
    assign over_full = analog_voltage_input_i > MV_FULL_SCALE;
    assign steps = analog_voltage_input_i / MV_PER_STEP;
    assign sample_d = over_full ? SAMPLE_MAX : steps[SAMPLE_W-1:0];

    // sample register, captured only when the converter offers a value
    logic [SAMPLE_W-1:0] sample_q;
    logic valid_q;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sample_q <= '0;
            valid_q <= 1'b0;
        end else begin
            valid_q <= analog_voltage_valid_i;
            if (analog_voltage_valid_i) begin
                sample_q <= sample_d;
            end
        end
    end

    assign sample_o = sample_q;
    assign sample_valid_o = valid_q;

    // ************************************************************
    // checks
    // ************************************************************
    a_sample_never_over: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        sample_q <= SAMPLE_MAX)
        else $error("sample above full scale");

    a_saturate_at_full: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        analog_voltage_valid_i && analog_voltage_input_i >= MV_FULL_SCALE |=> sample_q == SAMPLE_MAX)
        else $error("full-scale input did not give 1000");

    a_linear_map: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        analog_voltage_valid_i && analog_voltage_input_i < MV_FULL_SCALE
        |=> sample_q == $past(analog_voltage_input_i) / MV_PER_STEP)
        else $error("sample not voltage over ten millivolts");

endmodule : input_quantizer

`default_nettype wire

// file: scaler_pkg.sv

`default_nettype none

package scaler_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int MV_W = 16;       // input voltage in millivolts
    localparam int SAMPLE_W = 10;   // internal sample 0..1000
    localparam int GAIN_W = 12;     // gain in hundredths
    localparam int OFFSET_W = 16;
    localparam int VALUE_W = 16;    // result field
    localparam int PROD_W = 22;     // 1000 * 1000 fits with sign

    // ************************************************************
    // scaling constants
    // ************************************************************
    localparam logic [MV_W-1:0] MV_FULL_SCALE = 16'd10000;
    localparam logic [MV_W-1:0] MV_PER_STEP = 16'd10;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 10'd1000;
    localparam logic signed [PROD_W-1:0] GAIN_DIVISOR = 22'sd100;
    localparam logic signed [GAIN_W-1:0] GAIN_MIN = -12'sd1000;
    localparam logic signed [GAIN_W-1:0] GAIN_MAX = 12'sd1000;
    localparam logic signed [OFFSET_W-1:0] OFFSET_MIN = -16'sd10000;
    localparam logic signed [OFFSET_W-1:0] OFFSET_MAX = 16'sd10000;

    // ************************************************************
    // reset values: unity gain, no shift
    // ************************************************************
    localparam logic signed [GAIN_W-1:0] GAIN_RESET = 12'sd100;
    localparam logic signed [OFFSET_W-1:0] OFFSET_RESET = 16'sd0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic signed [GAIN_W-1:0] gain;     // hundredths
        logic signed [OFFSET_W-1:0] offset;
    } scale_cfg_s;

    // true when a value lies in [lo, hi], used for both settings
    function automatic logic in_range(input logic signed [OFFSET_W-1:0] v,
                                      input logic signed [OFFSET_W-1:0] lo,
                                      input logic signed [OFFSET_W-1:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

endpackage : scaler_pkg

`default_nettype wire
